// >>> verilog/mic_pkg.sv
// constants of the interrupt unit: source counts, register map, fields, reset values
`default_nettype none
package mic_pkg;
  // source layout
  localparam int NUM_PERIPH = 76;
  localparam int NUM_PIN = 6;
  localparam int PIN_BASE = 76;
  localparam int SW_SRC = 82;
  localparam int NUM_SRC = 83;
  localparam int NUM_XFER = 52;
  localparam int NUM_XFER_PERIPH = 45;
  localparam int VEC_W = 7;
  localparam int PRIO_W = 4;
  localparam int NUM_FILT = 7;
  localparam int NM_FILT = 6;

  // register offsets, byte addresses
  localparam logic [7:0] OFF_SRC_SEL = 8'h00;
  localparam logic [7:0] OFF_SRC_CFG = 8'h04;
  localparam logic [7:0] OFF_FAST_SEL = 8'h08;
  localparam logic [7:0] OFF_SW_TRIG = 8'h0c;
  localparam logic [7:0] OFF_PIN_MODE = 8'h10;
  localparam logic [7:0] OFF_PIN_FILT_EN = 8'h14;
  localparam logic [7:0] OFF_PIN_FILT_CLK = 8'h18;
  localparam logic [7:0] OFF_NM_STATUS = 8'h1c;
  localparam logic [7:0] OFF_NM_ENABLE = 8'h20;
  localparam logic [7:0] OFF_NM_CLEAR = 8'h24;
  localparam logic [7:0] OFF_NM_FILT_EN = 8'h28;
  localparam logic [7:0] OFF_NM_FILT_CLK = 8'h2c;
  localparam logic [7:0] OFF_NM_EDGE = 8'h30;
  localparam logic [7:0] OFF_EVT_STATUS = 8'h34;
  localparam logic [7:0] OFF_EVT_MASK = 8'h38;
  localparam logic [7:0] OFF_CPU_STATE = 8'h3c;

  // source config and fast select word fields
  localparam int CFG_PRIO_LSB = 0;
  localparam int CFG_EN_BIT = 4;
  localparam int CFG_XFER_BIT = 5;
  localparam int CFG_PEND_BIT = 6;
  localparam int FAST_VALID_BIT = 7;

  // nonmask status / enable / clear bits
  localparam int NM_W = 5;
  localparam int NM_PIN_BIT = 0;
  localparam int NM_OSC_BIT = 1;
  localparam int NM_WDOG_BIT = 2;
  localparam int NM_VMON1_BIT = 3;
  localparam int NM_VMON2_BIT = 4;

  // event status bits: pins 0..5, software, nonmask
  localparam int EVT_W = 8;
  localparam int EVT_SW_BIT = 6;
  localparam int EVT_NM_BIT = 7;

  // pin detection modes
  localparam logic [1:0] MODE_LOW = 2'h0;
  localparam logic [1:0] MODE_FALL = 2'h1;
  localparam logic [1:0] MODE_RISE = 2'h2;
  localparam logic [1:0] MODE_BOTH = 2'h3;

  // filter: agreeing samples and sampling divider masks
  localparam int FILT_SAMPLES = 3;
  localparam int DIV_W = 6;
  localparam logic [5:0] DIV_MASK_1 = 6'h07;
  localparam logic [5:0] DIV_MASK_2 = 6'h1f;
  localparam logic [5:0] DIV_MASK_3 = 6'h3f;

  // reset values
  localparam logic [11:0] PIN_MODE_RST = 12'h000;
  localparam logic [NM_W-1:0] NM_EN_RST = 5'h00;
  localparam logic [EVT_W-1:0] EVT_MASK_RST = 8'h00;
  localparam logic [PRIO_W-1:0] PRIO_RST = 4'h0;
endpackage
`default_nettype wire

// >>> verilog/mic_interrupt_unit.sv
// interrupt unit: source detection, pin filters, priority, nonmask logic, wakeup
//
// Notes on behaviour
// - 76 peripheral sources; edge or level fixed per source by parameter.
// - six pins, each low level, falling, rising or both edges.
// - each pin has an enable switching a digital filter in.
// - each pin filter has a two-bit sampling clock select.
// - any write to the trigger register raises the software source.
// - per-source priority decides which pending request goes to the CPU.
// - at most one source can be marked for the fast path.
// - 45 peripheral, six pin and the software source can go to transfers.
// - nonmask pin raises on falling or rising edge, as selected.
// - nonmask pin filter has its own enable and clock select.
// - main oscillator stop raises a nonmask interrupt.
// - watchdog underflow or refresh error raises a nonmask interrupt.
// - watchdog, monitor 1 and 2 flags each have a clear bit.
// - watchdog, monitor 1 and 2 request only when enabled.
// - separate nonmask interrupts for voltage monitors one and two.
// - in sleep any nonmask or other interrupt starts the return.
// - in standby only nonmask or pin interrupts start the return.
//
// Decided for this implementation: the address map and the Wishbone slave port.
`default_nettype none
module mic_interrupt_unit #(
  parameter logic [mic_pkg::NUM_PERIPH-1:0] PERIPH_EDGE = '0
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // interrupt sources
  input wire logic [mic_pkg::NUM_PERIPH-1:0] periph_req_i,
  input wire logic [mic_pkg::NUM_PIN-1:0] ext_pin_i,
  input wire logic nonmask_pin_i,
  input wire logic osc_stop_i,
  input wire logic wdog_event_i,
  input wire logic vmon1_event_i,
  input wire logic vmon2_event_i,
  // cpu side
  output logic cpu_irq_o,
  output logic [mic_pkg::VEC_W-1:0] cpu_vec_o,
  output logic [mic_pkg::PRIO_W-1:0] cpu_lvl_o,
  output logic cpu_fast_o,
  input wire logic cpu_ack_i,
  output logic cpu_nmi_o,
  // transfer controller side
  output logic [mic_pkg::NUM_XFER-1:0] xfer_req_o,
  input wire logic [mic_pkg::NUM_XFER-1:0] xfer_ack_i,
  // power modes
  input wire logic sleep_i,
  input wire logic standby_i,
  output logic wake_o,
  // block interrupt
  output logic irq_o
);
  localparam int NS = mic_pkg::NUM_SRC;

  // source number served by transfer request j
  function automatic int xfer_src(input int j);
    xfer_src = (j < mic_pkg::NUM_XFER_PERIPH) ? j : j + (mic_pkg::PIN_BASE - mic_pkg::NUM_XFER_PERIPH);
  endfunction

  function automatic logic xfer_ok(input int k);
    xfer_ok = (k < mic_pkg::NUM_XFER_PERIPH) || (k >= mic_pkg::PIN_BASE);
  endfunction

  // sampling strobe for a filter clock select
  function automatic logic filt_tick(input logic [1:0] sel, input logic [5:0] cnt);
    case (sel)
      2'h0: filt_tick = 1'b1;
      2'h1: filt_tick = (cnt & mic_pkg::DIV_MASK_1) == 6'h00;
      2'h2: filt_tick = (cnt & mic_pkg::DIV_MASK_2) == 6'h00;
      default: filt_tick = (cnt & mic_pkg::DIV_MASK_3) == 6'h00;
    endcase
  endfunction

  // byte-lane merge for registers up to 16 bits
  function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d,
                                        input logic [3:0] sel);
    merge = {sel[1] ? d[15:8] : old[15:8], sel[0] ? d[7:0] : old[7:0]};
  endfunction

  // registers
  logic [mic_pkg::VEC_W-1:0] src_sel_r;
  logic [mic_pkg::PRIO_W-1:0] prio_r [NS];
  logic [NS-1:0] ien_r;
  logic [NS-1:0] xen_r;
  logic [7:0] fast_r;
  logic [11:0] pin_mode_r;
  logic [mic_pkg::NUM_PIN-1:0] pin_fen_r;
  logic [11:0] pin_fclk_r;
  logic [mic_pkg::NM_W-1:0] nm_stat_r;
  logic [mic_pkg::NM_W-1:0] nm_en_r;
  logic nm_fen_r;
  logic [1:0] nm_fclk_r;
  logic nm_rise_r;
  logic [mic_pkg::EVT_W-1:0] evt_stat_r;
  logic [mic_pkg::EVT_W-1:0] evt_mask_r;
  logic [NS-1:0] pend_r;
  logic [mic_pkg::NUM_PERIPH-1:0] periph_prev_r;
  logic [mic_pkg::DIV_W-1:0] div_r;
  logic [mic_pkg::FILT_SAMPLES-1:0] hist_r [mic_pkg::NUM_FILT];
  logic [mic_pkg::NUM_FILT-1:0] filt_r;
  logic [mic_pkg::NUM_FILT-1:0] lvl_prev_r;
  logic ack_r;
  logic [31:0] rdata_r;
  logic irq_r;
  logic [mic_pkg::VEC_W-1:0] vec_r;
  logic [mic_pkg::PRIO_W-1:0] lvl_r;
  logic fast_out_r;

  // bus decode
  wire req = wb_cyc_i & wb_stb_i;
  wire wr_stb = req & wb_we_i & ack_r;
  wire [5:0] word = wb_adr_i[7:2];
  wire hit_sel = word == mic_pkg::OFF_SRC_SEL[7:2];
  wire hit_cfg = word == mic_pkg::OFF_SRC_CFG[7:2];
  wire hit_fast = word == mic_pkg::OFF_FAST_SEL[7:2];
  wire hit_sw = word == mic_pkg::OFF_SW_TRIG[7:2];
  wire hit_mode = word == mic_pkg::OFF_PIN_MODE[7:2];
  wire hit_pfen = word == mic_pkg::OFF_PIN_FILT_EN[7:2];
  wire hit_pfclk = word == mic_pkg::OFF_PIN_FILT_CLK[7:2];
  wire hit_nmst = word == mic_pkg::OFF_NM_STATUS[7:2];
  wire hit_nmen = word == mic_pkg::OFF_NM_ENABLE[7:2];
  wire hit_nmclr = word == mic_pkg::OFF_NM_CLEAR[7:2];
  wire hit_nmfen = word == mic_pkg::OFF_NM_FILT_EN[7:2];
  wire hit_nmfclk = word == mic_pkg::OFF_NM_FILT_CLK[7:2];
  wire hit_nmedge = word == mic_pkg::OFF_NM_EDGE[7:2];
  wire hit_evst = word == mic_pkg::OFF_EVT_STATUS[7:2];
  wire hit_evmk = word == mic_pkg::OFF_EVT_MASK[7:2];
  wire hit_cpu = word == mic_pkg::OFF_CPU_STATE[7:2];
  wire sel_ok = src_sel_r < mic_pkg::VEC_W'(NS);
  wire [15:0] wmerge_fast = merge({8'h00, fast_r}, wb_dat_i, wb_sel_i);
  wire [15:0] wmerge_mode = merge({4'h0, pin_mode_r}, wb_dat_i, wb_sel_i);
  wire [15:0] wmerge_pfclk = merge({4'h0, pin_fclk_r}, wb_dat_i, wb_sel_i);
  wire [7:0] wlo = wb_sel_i[0] ? wb_dat_i[7:0] : 8'h00;
  wire wr_cfg = wr_stb & hit_cfg & sel_ok & wb_sel_i[0];
  wire [mic_pkg::NM_W-1:0] nm_clr = (wr_stb & hit_nmclr) ? wlo[mic_pkg::NM_W-1:0] : '0;
  wire [mic_pkg::EVT_W-1:0] evt_clr = (wr_stb & hit_evst) ? wlo : '0;
  wire sw_set = wr_stb & hit_sw;

  // filters: pins 0..5 then the nonmask pin
  wire [mic_pkg::NUM_FILT-1:0] raw = {nonmask_pin_i, ext_pin_i};
  wire [mic_pkg::NUM_FILT-1:0] fen = {nm_fen_r, pin_fen_r};
  wire [2*mic_pkg::NUM_FILT-1:0] fclk_all = {nm_fclk_r, pin_fclk_r};
  logic [mic_pkg::NUM_FILT-1:0] tick;
  logic [mic_pkg::NUM_FILT-1:0] lvl;
  always_comb begin
    for (int i = 0; i < mic_pkg::NUM_FILT; i++) begin
      tick[i] = filt_tick(fclk_all[2*i +: 2], div_r);
      lvl[i] = fen[i] ? filt_r[i] : raw[i];
    end
  end
  wire [mic_pkg::NUM_FILT-1:0] rise = lvl & ~lvl_prev_r;
  wire [mic_pkg::NUM_FILT-1:0] fall = ~lvl & lvl_prev_r;

  // source detection
  logic [NS-1:0] src_edge;
  logic [NS-1:0] src_set;
  logic [NS-1:0] src_lvl;
  logic [mic_pkg::NUM_PIN-1:0] pin_hit;
  always_comb begin
    // peripheral edge or level per parameter
    src_edge[mic_pkg::NUM_PERIPH-1:0] = PERIPH_EDGE;
    src_set[mic_pkg::NUM_PERIPH-1:0] = PERIPH_EDGE & periph_req_i & ~periph_prev_r;
    src_lvl[mic_pkg::NUM_PERIPH-1:0] = periph_req_i;
    for (int p = 0; p < mic_pkg::NUM_PIN; p++) begin
      case (pin_mode_r[2*p +: 2])
        mic_pkg::MODE_LOW: pin_hit[p] = 1'b0;
        mic_pkg::MODE_FALL: pin_hit[p] = fall[p];
        mic_pkg::MODE_RISE: pin_hit[p] = rise[p];
        default: pin_hit[p] = rise[p] | fall[p];
      endcase
      src_edge[mic_pkg::PIN_BASE+p] = pin_mode_r[2*p +: 2] != mic_pkg::MODE_LOW;
      src_set[mic_pkg::PIN_BASE+p] = pin_hit[p];
      src_lvl[mic_pkg::PIN_BASE+p] = ~lvl[p];
    end
    src_edge[mic_pkg::SW_SRC] = 1'b1;
    src_set[mic_pkg::SW_SRC] = sw_set;
    src_lvl[mic_pkg::SW_SRC] = 1'b0;
  end

  wire [NS-1:0] active = (src_edge & pend_r) | (~src_edge & src_lvl);

  // acknowledge clears of edge pending flags
  logic [NS-1:0] pend_clr;
  always_comb begin
    pend_clr = '0;
    if (cpu_ack_i && irq_r) begin
      pend_clr[vec_r] = 1'b1;
    end
    for (int j = 0; j < mic_pkg::NUM_XFER; j++) begin
      pend_clr[xfer_src(j)] = pend_clr[xfer_src(j)] | xfer_ack_i[j];
    end
  end

  always_comb begin
    for (int j = 0; j < mic_pkg::NUM_XFER; j++) begin
      xfer_req_o[j] = active[xfer_src(j)] & ien_r[xfer_src(j)] & xen_r[xfer_src(j)];
    end
  end

  // highest priority wins, lowest number on a tie
  logic [NS-1:0] elig;
  logic [mic_pkg::PRIO_W-1:0] best_lvl;
  logic [mic_pkg::VEC_W-1:0] best_vec;
  always_comb begin
    best_lvl = '0;
    best_vec = '0;
    for (int k = 0; k < NS; k++) begin
      elig[k] = active[k] & ien_r[k] & ~xen_r[k] & (prio_r[k] != '0);
      if (elig[k] && prio_r[k] > best_lvl) begin
        best_lvl = prio_r[k];
        best_vec = mic_pkg::VEC_W'(k);
      end
    end
  end

  // nonmask sources
  logic [mic_pkg::NM_W-1:0] nm_set;
  always_comb begin
    nm_set = '0;
    nm_set[mic_pkg::NM_PIN_BIT] = nm_rise_r ? rise[mic_pkg::NM_FILT] : fall[mic_pkg::NM_FILT];
    nm_set[mic_pkg::NM_OSC_BIT] = osc_stop_i;
    nm_set[mic_pkg::NM_WDOG_BIT] = wdog_event_i;
    nm_set[mic_pkg::NM_VMON1_BIT] = vmon1_event_i;
    nm_set[mic_pkg::NM_VMON2_BIT] = vmon2_event_i;
  end
  wire [mic_pkg::EVT_W-1:0] evt_set = {|nm_set, sw_set, pin_hit};

  // read mux
  wire [31:0] cfg_rd = sel_ok ? {25'h0, pend_r[src_sel_r], xen_r[src_sel_r], ien_r[src_sel_r],
                                 prio_r[src_sel_r]} : 32'h0;
  wire [31:0] rd_val =
    hit_sel ? {25'h0, src_sel_r} :
    hit_cfg ? cfg_rd :
    hit_fast ? {24'h0, fast_r} :
    hit_mode ? {20'h0, pin_mode_r} :
    hit_pfen ? {26'h0, pin_fen_r} :
    hit_pfclk ? {20'h0, pin_fclk_r} :
    hit_nmst ? {27'h0, nm_stat_r} :
    hit_nmen ? {27'h0, nm_en_r} :
    hit_nmfen ? {31'h0, nm_fen_r} :
    hit_nmfclk ? {30'h0, nm_fclk_r} :
    hit_nmedge ? {31'h0, nm_rise_r} :
    hit_evst ? {24'h0, evt_stat_r} :
    hit_evmk ? {24'h0, evt_mask_r} :
    hit_cpu ? {19'h0, fast_out_r, lvl_r, irq_r, vec_r} : 32'h0;

  // bus handshake and read data
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      rdata_r <= '0;
    end else begin
      ack_r <= req & ~ack_r;
      if (req && !ack_r) begin
        rdata_r <= rd_val;
      end
    end
  end

  // configuration registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      src_sel_r <= '0;
      fast_r <= '0;
      pin_mode_r <= mic_pkg::PIN_MODE_RST;
      pin_fen_r <= '0;
      pin_fclk_r <= '0;
      nm_en_r <= mic_pkg::NM_EN_RST;
      nm_fen_r <= 1'b0;
      nm_fclk_r <= '0;
      nm_rise_r <= 1'b0;
      evt_mask_r <= mic_pkg::EVT_MASK_RST;
    end else if (wr_stb) begin
      if (hit_sel && wb_sel_i[0]) src_sel_r <= wb_dat_i[mic_pkg::VEC_W-1:0];
      if (hit_fast) fast_r <= wmerge_fast[7:0];
      if (hit_mode) pin_mode_r <= wmerge_mode[11:0];
      if (hit_pfen) pin_fen_r <= wlo[mic_pkg::NUM_PIN-1:0] | (wb_sel_i[0] ? '0 : pin_fen_r);
      if (hit_pfclk) pin_fclk_r <= wmerge_pfclk[11:0];
      if (hit_nmen && wb_sel_i[0]) nm_en_r <= wb_dat_i[mic_pkg::NM_W-1:0];
      if (hit_nmfen && wb_sel_i[0]) nm_fen_r <= wb_dat_i[0];
      if (hit_nmfclk && wb_sel_i[0]) nm_fclk_r <= wb_dat_i[1:0];
      if (hit_nmedge && wb_sel_i[0]) nm_rise_r <= wb_dat_i[0];
      if (hit_evmk && wb_sel_i[0]) evt_mask_r <= wb_dat_i[mic_pkg::EVT_W-1:0];
    end
  end

  // per-source priority, enable and routing
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ien_r <= '0;
      xen_r <= '0;
      for (int k = 0; k < NS; k++) prio_r[k] <= mic_pkg::PRIO_RST;
    end else if (wr_cfg) begin
      prio_r[src_sel_r] <= wb_dat_i[mic_pkg::CFG_PRIO_LSB +: mic_pkg::PRIO_W];
      ien_r[src_sel_r] <= wb_dat_i[mic_pkg::CFG_EN_BIT];
      xen_r[src_sel_r] <= wb_dat_i[mic_pkg::CFG_XFER_BIT] & xfer_ok(int'(src_sel_r));
    end
  end

  // pending flags, set wins over clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pend_r <= '0;
      periph_prev_r <= '0;
    end else begin
      pend_r <= src_edge & (src_set | (pend_r & ~pend_clr));
      periph_prev_r <= periph_req_i;
    end
  end

  // three agreeing samples pass a new level
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_r <= '0;
      filt_r <= '1;
      lvl_prev_r <= '1;
      for (int i = 0; i < mic_pkg::NUM_FILT; i++) hist_r[i] <= '1;
    end else begin
      div_r <= div_r + 6'h01;
      lvl_prev_r <= lvl;
      for (int i = 0; i < mic_pkg::NUM_FILT; i++) begin
        if (tick[i]) begin
          hist_r[i] <= {hist_r[i][mic_pkg::FILT_SAMPLES-2:0], raw[i]};
          if (&{hist_r[i][mic_pkg::FILT_SAMPLES-2:0], raw[i]}) filt_r[i] <= 1'b1;
          if (~|{hist_r[i][mic_pkg::FILT_SAMPLES-2:0], raw[i]}) filt_r[i] <= 1'b0;
        end
      end
    end
  end

  // sticky nonmask and event flags, cleared by write of one
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      nm_stat_r <= '0;
      evt_stat_r <= '0;
    end else begin
      nm_stat_r <= nm_set | (nm_stat_r & ~nm_clr);
      evt_stat_r <= evt_set | (evt_stat_r & ~evt_clr);
    end
  end

  // cpu request outputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_r <= 1'b0;
      vec_r <= '0;
      lvl_r <= '0;
      fast_out_r <= 1'b0;
    end else begin
      irq_r <= best_lvl != '0;
      vec_r <= best_vec;
      lvl_r <= best_lvl;
      // fast only for the one chosen source
      fast_out_r <= (best_lvl != '0) & fast_r[mic_pkg::FAST_VALID_BIT]
                    & (fast_r[mic_pkg::VEC_W-1:0] == best_vec);
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdata_r;
  assign cpu_irq_o = irq_r;
  assign cpu_vec_o = vec_r;
  assign cpu_lvl_o = lvl_r;
  assign cpu_fast_o = fast_out_r;
  assign cpu_nmi_o = |(nm_stat_r & nm_en_r);
  assign irq_o = |(evt_stat_r & evt_mask_r);

  wire pin_wake = |(active[mic_pkg::PIN_BASE +: mic_pkg::NUM_PIN]
                    & ien_r[mic_pkg::PIN_BASE +: mic_pkg::NUM_PIN]);
  assign wake_o = (sleep_i & (cpu_nmi_o | (|elig) | (|xfer_req_o)))
                | (standby_i & (cpu_nmi_o | pin_wake));
endmodule // mic_interrupt_unit
`default_nettype wire

// >>> test/mic_asserts.sv
// port checker of the interrupt unit: bus handshake, sticky flags, wake
`default_nettype none
module mic_asserts (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // cpu, power and block interrupt
  input wire logic cpu_irq_o,
  input wire logic [mic_pkg::VEC_W-1:0] cpu_vec_o,
  input wire logic [mic_pkg::PRIO_W-1:0] cpu_lvl_o,
  input wire logic cpu_nmi_o,
  input wire logic sleep_i,
  input wire logic standby_i,
  input wire logic wake_o,
  input wire logic irq_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking dcb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  chk_ack_latency: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus ack missing");
  chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("bus ack too long");
  chk_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("bus ack without request");
  chk_unmapped_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i > 8'h3f
    |-> wb_dat_o == 32'h0) else $error("unmapped read not zero");
  chk_nmi_sticky: assert property (cpu_nmi_o && !(wb_ack_o && wb_we_i)
    && !$past(wb_ack_o && wb_we_i) |=> cpu_nmi_o) else $error("nmi fell alone");
  chk_evt_sticky: assert property (irq_o && !(wb_ack_o && wb_we_i)
    && !$past(wb_ack_o && wb_we_i) |=> irq_o) else $error("irq fell alone");
  chk_prio_nonzero: assert property (cpu_irq_o |-> cpu_lvl_o != 4'h0)
    else $error("level zero at cpu");
  chk_vec_range: assert property (cpu_irq_o |-> cpu_vec_o <= 7'h52)
    else $error("vector out of range");
  chk_sleep_wake: assert property (sleep_i && cpu_nmi_o |-> wake_o)
    else $error("no wake in sleep");
  chk_standby_wake: assert property (standby_i && cpu_nmi_o |-> wake_o)
    else $error("no wake in standby");
endmodule // mic_asserts
bind mic_interrupt_unit mic_asserts mic_asserts_inst (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .cpu_irq_o(cpu_irq_o), .cpu_vec_o(cpu_vec_o),
  .cpu_lvl_o(cpu_lvl_o), .cpu_nmi_o(cpu_nmi_o), .sleep_i(sleep_i), .standby_i(standby_i),
  .wake_o(wake_o), .irq_o(irq_o));
`default_nettype wire

// >>> test/mic_cpu_model.sv
// cpu model: acknowledges the presented request after a set delay
`default_nettype none
module mic_cpu_model (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // request and answer
  input wire logic cpu_irq_i,
  input wire logic [3:0] delay_i,
  output logic cpu_ack_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] cnt_r;
  logic [1:0] gap_r;
  // one pulse per wait, then a gap while the request falls
  always_ff @(posedge clk_i) begin
    cpu_ack_o <= 1'b0;
    if (rst_i) begin
      cnt_r <= 4'h0;
      gap_r <= 2'h0;
    end else if (gap_r != 2'h0) begin
      gap_r <= gap_r - 2'h1;
    end else if (!cpu_irq_i) begin
      cnt_r <= 4'h0;
    end else if (cnt_r >= delay_i) begin
      cpu_ack_o <= 1'b1;
      cnt_r <= 4'h0;
      gap_r <= 2'h3;
    end else begin
      cnt_r <= cnt_r + 4'h1;
    end
  end
endmodule // mic_cpu_model
`default_nettype wire

// >>> test/mic_interrupt_unit_tb_top.sv
// bench of the interrupt unit: bus, priority, software, pins, nonmask, wake
`default_nettype none
module mic_interrupt_unit_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, we = 1'b0, slp = 1'b0, sby = 1'b0;
  logic npin = 1'b1;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat = 32'h0, rd, q;
  logic [75:0] preq = '0;
  logic [5:0] pin = 6'h3f;
  logic [3:0] nev = 4'h0, dly = 4'h0, lvl;
  logic [51:0] xack = '0, xreq;
  logic [6:0] vec;
  logic ack, irq, fast, nmi, wake, birq, cack;
  int num_errors = 0;
  int n_checks = 0;
  initial forever #50 clk_i = ~clk_i;
  mic_interrupt_unit #(.PERIPH_EDGE(76'h8)) mic_interrupt_unit_inst (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(rd), .wb_ack_o(ack),
    .periph_req_i(preq), .ext_pin_i(pin), .nonmask_pin_i(npin), .osc_stop_i(nev[0]),
    .wdog_event_i(nev[1]), .vmon1_event_i(nev[2]), .vmon2_event_i(nev[3]),
    .cpu_irq_o(irq), .cpu_vec_o(vec), .cpu_lvl_o(lvl), .cpu_fast_o(fast),
    .cpu_ack_i(cack), .cpu_nmi_o(nmi), .xfer_req_o(xreq), .xfer_ack_i(xack),
    .sleep_i(slp), .standby_i(sby), .wake_o(wake), .irq_o(birq));
  mic_cpu_model mic_cpu_model_inst (.clk_i(clk_i), .rst_i(rst_i), .cpu_irq_i(irq),
    .delay_i(dly), .cpu_ack_o(cack));
  task automatic wrap_up();
    if (num_errors == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %0t %s", $time, m);
    end
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = rd;
    cyc <= 1'b0;
    we <= 1'b0;
    chk(32'(ack), 32'h1, "bus wait");
    if (ack !== 1'b1) begin
      wrap_up();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
    input string s);
    wb(1'b0, a, 32'h0);
    chk(q & m, e, s);
  endtask
  task automatic cfg(input logic [6:0] s, input logic [5:0] v);
    wr(mic_pkg::OFF_SRC_SEL, 32'(s));
    wr(mic_pkg::OFF_SRC_CFG, 32'(v));
  endtask
  task automatic wait_cpu(input logic i, input logic [6:0] v);
    int n;
    n = 0;
    while ((irq !== i || (i && vec !== v)) && n < 80) begin
      @(posedge clk_i);
      n++;
    end
    chk(32'(n < 80), 32'h1, "cpu wait");
    if (n >= 80) begin
      wrap_up();
    end
  endtask
  task automatic glitch(input int b, input int len, input int tail);
    pin[b] <= 1'b0;
    settle(len);
    pin[b] <= 1'b1;
    settle(tail);
  endtask
  task automatic t_regs();
    rdc(mic_pkg::OFF_PIN_MODE, 32'hfff, 32'(mic_pkg::PIN_MODE_RST), "mode");
    rdc(mic_pkg::OFF_NM_ENABLE, 32'h1f, 32'(mic_pkg::NM_EN_RST), "nm en");
    wr(8'h40, 32'hffff);
    rdc(8'h40, 32'hffffffff, 32'h0, "unmapped");
  endtask
  task automatic t_prio();
    dly <= 4'h8;
    wr(mic_pkg::OFF_FAST_SEL, 32'h83);
    cfg(7'd3, 6'h12);
    cfg(7'd10, 6'h15);
    cfg(7'd20, 6'h10);
    preq[20] <= 1'b1;
    settle(5);
    chk(32'(irq), 32'h0, "prio zero");
    preq[10] <= 1'b1;
    preq[3] <= 1'b1;
    @(posedge clk_i);
    preq[3] <= 1'b0;
    wait_cpu(1'b1, 7'd10);
    chk(32'({lvl, fast}), 32'h0a, "high");
    rdc(mic_pkg::OFF_CPU_STATE, 32'h1fff, 32'h58a, "cpu state");
    preq[10] <= 1'b0;
    wait_cpu(1'b1, 7'd3);
    chk(32'({lvl, fast}), 32'h05, "low");
    wait_cpu(1'b0, 7'd0);
    preq[20] <= 1'b0;
    dly <= 4'h0;
  endtask
  task automatic t_soft();
    cfg(7'd82, 6'h31);
    cfg(7'd5, 6'h31);
    preq[5] <= 1'b1;
    wr(mic_pkg::OFF_EVT_MASK, 32'h40);
    wr(mic_pkg::OFF_SW_TRIG, 32'h0);
    settle(2);
    chk(32'({birq, xreq[51], xreq[5], irq}), 32'he, "soft");
    xack[51] <= 1'b1;
    preq[5] <= 1'b0;
    @(posedge clk_i);
    xack[51] <= 1'b0;
    settle(2);
    chk(32'({xreq[51], xreq[5]}), 32'h0, "xfer ack");
    wr(mic_pkg::OFF_EVT_MASK, 32'h0);
    settle(2);
    chk(32'(birq), 32'h0, "masked");
    rdc(mic_pkg::OFF_EVT_STATUS, 32'h40, 32'h40, "status");
    wr(mic_pkg::OFF_EVT_MASK, 32'h40);
    wr(mic_pkg::OFF_EVT_STATUS, 32'h40);
    settle(2);
    chk(32'(birq), 32'h0, "w1c");
  endtask
  task automatic t_pins();
    logic [1:0] m;
    cfg(7'd76, 6'h13);
    pin[0] <= 1'b0;
    wait_cpu(1'b1, 7'd76);
    pin[0] <= 1'b1;
    wait_cpu(1'b0, 7'd0);
    for (int k = 1; k < 4; k++) begin
      m = 2'(k);
      wr(mic_pkg::OFF_PIN_MODE, 32'(m));
      wr(mic_pkg::OFF_EVT_STATUS, 32'hff);
      pin[0] <= 1'b0;
      settle(3);
      rdc(mic_pkg::OFF_EVT_STATUS, 32'h1, 32'(m != mic_pkg::MODE_RISE), "fall");
      wr(mic_pkg::OFF_EVT_STATUS, 32'hff);
      pin[0] <= 1'b1;
      settle(3);
      rdc(mic_pkg::OFF_EVT_STATUS, 32'h1, 32'(m != mic_pkg::MODE_FALL), "rise");
    end
    wr(mic_pkg::OFF_EVT_STATUS, 32'hff);
    glitch(0, 1, 3);
    rdc(mic_pkg::OFF_EVT_STATUS, 32'h1, 32'h1, "bypass");
    wr(mic_pkg::OFF_PIN_MODE, 32'h4);
    wr(mic_pkg::OFF_PIN_FILT_EN, 32'h2);
    for (int s = 0; s < 4; s++) begin
      wr(mic_pkg::OFF_PIN_FILT_CLK, 32'(s) << 2);
      wr(mic_pkg::OFF_EVT_STATUS, 32'hff);
      glitch(1, 2, 260);
      rdc(mic_pkg::OFF_EVT_STATUS, 32'h2, 32'h0, "glitch");
      glitch(1, 260, 260);
      rdc(mic_pkg::OFF_EVT_STATUS, 32'h2, 32'h2, "filtered");
    end
  endtask
  task automatic t_nm();
    for (int b = 0; b < 4; b++) begin
      nev[b] <= 1'b1;
      @(posedge clk_i);
      nev[b] <= 1'b0;
      settle(2);
      chk(32'(nmi), 32'h0, "nm off");
      rdc(mic_pkg::OFF_NM_STATUS, 32'h1f, 32'h2 << b, "nm st");
      wr(mic_pkg::OFF_NM_ENABLE, 32'h2 << b);
      settle(2);
      chk(32'(nmi), 32'h1, "nm on");
      wr(mic_pkg::OFF_NM_CLEAR, 32'h2 << b);
      settle(2);
      chk(32'(nmi), 32'h0, "nm clr");
      wr(mic_pkg::OFF_NM_ENABLE, 32'h0);
    end
    wr(mic_pkg::OFF_NM_FILT_EN, 32'h1);
    wr(mic_pkg::OFF_NM_FILT_CLK, 32'h0);
    wr(mic_pkg::OFF_NM_EDGE, 32'h1);
    npin <= 1'b0;
    settle(6);
    rdc(mic_pkg::OFF_NM_STATUS, 32'h1, 32'h0, "pin fall");
    npin <= 1'b1;
    settle(6);
    rdc(mic_pkg::OFF_NM_STATUS, 32'h1, 32'h1, "pin rise");
    wr(mic_pkg::OFF_NM_CLEAR, 32'h1);
    wr(mic_pkg::OFF_NM_EDGE, 32'h0);
    npin <= 1'b0;
    settle(2);
    npin <= 1'b1;
    settle(6);
    rdc(mic_pkg::OFF_NM_STATUS, 32'h1, 32'h0, "pin glitch");
    npin <= 1'b0;
    settle(6);
    rdc(mic_pkg::OFF_NM_STATUS, 32'h1, 32'h1, "pin low");
  endtask
  task automatic t_wake();
    cfg(7'd10, 6'h15);
    preq[10] <= 1'b1;
    sby <= 1'b1;
    settle(3);
    chk(32'(wake), 32'h0, "standby");
    sby <= 1'b0;
    slp <= 1'b1;
    settle(3);
    chk(32'(wake), 32'h1, "sleep");
    slp <= 1'b0;
    preq[10] <= 1'b0;
    cfg(7'd78, 6'h10);
    wr(mic_pkg::OFF_PIN_MODE, 32'h10);
    sby <= 1'b1;
    pin[2] <= 1'b0;
    settle(4);
    chk(32'(wake), 32'h1, "pin wake");
    wr(mic_pkg::OFF_NM_ENABLE, 32'h4);
    nev[1] <= 1'b1;
    @(posedge clk_i);
    nev[1] <= 1'b0;
    slp <= 1'b1;
    settle(3);
    chk(32'({nmi, wake}), 32'h3, "nm wake");
  endtask
  initial begin
    settle(10);
    rst_i <= 1'b0;
    t_regs();
    t_prio();
    t_soft();
    t_pins();
    t_nm();
    t_wake();
    wrap_up();
  end
endmodule // mic_interrupt_unit_tb_top
`default_nettype wire
